// ===== core/pidc_pkg.sv
// shared constants for the priority interrupt daisy-chain block
// assumes one 20 MHz system clock, all bus pins sampled synchronously
// Functional notes
// R1: interrupter pulls exactly one of seven active-low request lines; bus has ack line, chain.
// R2: single handler treats levels as prioritized, level 7 first.
// R3: handler sees only its assigned levels, picks highest active in 7..1.
// R4: handler wins data bus via own requester before starting acknowledge cycle.
// R5: after reading Status/ID, handler starts servicing with the returned value.
// R6: ack line low makes slot-1 chain driver launch falling edge down chain.
// R7: shared level: daisy-chain guarantees exactly one interrupter answers.
// R8: pending interrupter answers only after a falling edge on its chain input.
// R9: answering interrupter holds chain output high, never forwards the edge.
// R10: non-interrupting board copies chain input to chain output.
// R11: modules actively drive mandatory outputs unless always high.
// R12: undriven bused lines read high due to termination.
// R13: answer needs pending request, level match, requested width at least own size.
// R14: handler drives ack low, level on three low address lines, never data lines.
// R15: acknowledged interrupter puts Status/ID on data, then pulls data-ack low; the core enables data and data-ack in the same cycle.
package pidc_pkg;
	localparam int unsigned PIDC_LEVELS = 7;
	localparam int unsigned PIDC_LVL_W = 3;
	localparam int unsigned PIDC_DATA_W = 32;
	// width codes: 0 = byte, 1 = double byte, 2 = quad byte
	localparam logic [1:0] PIDC_W8 = 2'h0;
	localparam logic [1:0] PIDC_W16 = 2'h1;
	localparam logic [1:0] PIDC_W32 = 2'h2;
	localparam logic [2:0] PIDC_LVL_NONE = 3'h0;
	localparam logic [2:0] PIDC_LVL_MAX = 3'h7;
	localparam logic [6:0] PIDC_REQ_IDLE = 7'h7f;
	localparam logic [31:0] PIDC_DATA_IDLE = 32'hffffffff;
	typedef enum logic [2:0] {
		PIDC_H_IDLE,
		PIDC_H_BUSREQ,
		PIDC_H_ACK,
		PIDC_H_RELEASE
	} pidc_hstate_e;
	typedef enum logic [1:0] {
		PIDC_I_IDLE,
		PIDC_I_ANSWER,
		PIDC_I_PASS
	} pidc_istate_e;
endpackage

// ===== core/pidc_core.sv
// handler, interrupter and slot-1 chain driver of one board
// assumes all bus inputs synchronous to i_clk_sys; pins open-drain style
`timescale 1ns/1ps
module pidc_core (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// board options
	input wire logic i_slot1,
	input wire logic i_handler_en,
	input wire logic i_intr_en,
	input wire logic [6:0] i_level_mask,
	// on-board interrupter side
	input wire logic i_intr_req,
	input wire logic [2:0] i_intr_level,
	input wire logic [1:0] i_intr_size,
	input wire logic [31:0] i_intr_statid,
	output logic o_intr_taken,
	// on-board requester / processor side
	output logic o_dtb_want,
	input wire logic i_dtb_granted,
	output logic o_svc_valid,
	output logic [31:0] o_svc_statid,
	output logic [2:0] o_svc_level,
	// bus pins, sampled as levels; low is asserted
	input wire logic [6:0] i_irq_n,
	output logic [6:0] o_irq_n,
	output logic [6:0] o_irq_oe,
	input wire logic i_iack_n,
	output logic o_iack_n,
	output logic o_iack_oe,
	input wire logic i_iackin_n,
	output logic o_iackout_n,
	input wire logic [2:0] i_addr_lvl,
	output logic [2:0] o_addr_lvl,
	output logic o_addr_oe,
	input wire logic [1:0] i_req_width,
	output logic [1:0] o_req_width,
	input wire logic [31:0] i_data,
	output logic [31:0] o_data,
	output logic o_data_oe,
	input wire logic i_dtack_n,
	output logic o_dtack_n,
	output logic o_dtack_oe
);
	typedef struct packed {
		pidc_pkg::pidc_hstate_e hs;
		pidc_pkg::pidc_istate_e is;
		logic [2:0] hlvl;
		logic svc_valid;
		logic [31:0] svc_statid;
		logic iackin_d;
		logic chain_out_n;
		logic slot1_out_n;
		logic taken;
		logic [31:0] data;
	} pidc_state_s;

	pidc_state_s st_r;
	pidc_state_s st_nxt;

	function automatic logic [2:0] pidc_pick(input logic [6:0] act);
		logic [2:0] lvl;
		lvl = pidc_pkg::PIDC_LVL_NONE;
		for (int i = 0; i < pidc_pkg::PIDC_LEVELS; i++) begin
			if (act[i]) begin
				lvl = 3'(i + 1);
			end
		end
		return lvl;
	endfunction

	logic [6:0] pend;
	logic [2:0] best;
	logic chain_in_n;
	logic chain_fall;
	logic qualify;

	//////////////////////////////////////////////////////////////////
	// handler prioritisation over assigned levels only
	assign pend = ~i_irq_n & i_level_mask; // R3
	assign best = pidc_pick(pend); // R2 R3
	// slot 1 chain driver: ack line, registered one cycle, is the chain input
	assign chain_in_n = i_slot1 ? st_r.slot1_out_n : i_iackin_n; // R6
	assign chain_fall = st_r.iackin_d & ~chain_in_n;
	assign qualify = i_intr_en & i_intr_req & (i_addr_lvl == i_intr_level)
		& (i_req_width >= i_intr_size); // R13

	always_comb begin
		st_nxt = st_r;
		st_nxt.svc_valid = 1'b0;
		st_nxt.slot1_out_n = i_iack_n; // R6
		st_nxt.iackin_d = chain_in_n;
		//////////////////////////////////////////////////////////////
		// handler
		unique case (st_r.hs)
			pidc_pkg::PIDC_H_IDLE: begin
				if (i_handler_en && best != pidc_pkg::PIDC_LVL_NONE) begin
					st_nxt.hlvl = best;
					st_nxt.hs = pidc_pkg::PIDC_H_BUSREQ;
				end
			end
			pidc_pkg::PIDC_H_BUSREQ: begin
				if (i_dtb_granted) begin
					st_nxt.hs = pidc_pkg::PIDC_H_ACK; // R4
				end
			end
			pidc_pkg::PIDC_H_ACK: begin
				if (!i_dtack_n) begin
					st_nxt.svc_statid = i_data; // R5 R12
					st_nxt.svc_valid = 1'b1; // R5
					st_nxt.hs = pidc_pkg::PIDC_H_RELEASE;
				end
			end
			pidc_pkg::PIDC_H_RELEASE: begin
				if (i_dtack_n) begin
					st_nxt.hs = pidc_pkg::PIDC_H_IDLE;
				end
			end
			default: st_nxt.hs = pidc_pkg::PIDC_H_IDLE;
		endcase
		//////////////////////////////////////////////////////////////
		// interrupter and chain pass-through
		st_nxt.taken = 1'b0;
		unique case (st_r.is)
			pidc_pkg::PIDC_I_IDLE: begin
				st_nxt.chain_out_n = 1'b1;
				if (chain_fall) begin // R8
					if (qualify) begin
						st_nxt.data = i_intr_statid; // R15
						st_nxt.taken = 1'b1;
						st_nxt.is = pidc_pkg::PIDC_I_ANSWER; // R7
					end else begin
						st_nxt.chain_out_n = 1'b0; // R10 R13
						st_nxt.is = pidc_pkg::PIDC_I_PASS;
					end
				end
			end
			pidc_pkg::PIDC_I_ANSWER: begin
				st_nxt.chain_out_n = 1'b1; // R9
				if (chain_in_n) begin
					st_nxt.is = pidc_pkg::PIDC_I_IDLE;
				end
			end
			pidc_pkg::PIDC_I_PASS: begin
				st_nxt.chain_out_n = chain_in_n; // R10
				if (chain_in_n) begin
					st_nxt.is = pidc_pkg::PIDC_I_IDLE;
				end
			end
			default: st_nxt.is = pidc_pkg::PIDC_I_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st_r.hs <= pidc_pkg::PIDC_H_IDLE;
			st_r.is <= pidc_pkg::PIDC_I_IDLE;
			st_r.hlvl <= pidc_pkg::PIDC_LVL_NONE;
			st_r.svc_valid <= 1'b0;
			st_r.svc_statid <= pidc_pkg::PIDC_DATA_IDLE;
			st_r.iackin_d <= 1'b1;
			st_r.chain_out_n <= 1'b1;
			st_r.slot1_out_n <= 1'b1;
			st_r.taken <= 1'b0;
			st_r.data <= pidc_pkg::PIDC_DATA_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////
	// pin drive; request, ack and data-ack lines low only, high left to termination
	always_comb begin
		o_irq_n = pidc_pkg::PIDC_REQ_IDLE;
		o_irq_oe = 7'h00;
		if (i_intr_en && i_intr_req && i_intr_level != pidc_pkg::PIDC_LVL_NONE) begin
			o_irq_n[i_intr_level - 3'h1] = 1'b0; // R1
			o_irq_oe[i_intr_level - 3'h1] = 1'b1; // R1 R11
		end
	end

	// a non-interrupting board forwards its chain combinationally-free via register
	assign o_iackout_n = st_r.chain_out_n; // R9 R10 R11
	assign o_iack_n = 1'b0; // R14
	assign o_iack_oe = (st_r.hs == pidc_pkg::PIDC_H_ACK); // R14
	assign o_addr_lvl = st_r.hlvl; // R14
	assign o_addr_oe = (st_r.hs == pidc_pkg::PIDC_H_ACK);
	assign o_req_width = pidc_pkg::PIDC_W32;
	assign o_dtb_want = (st_r.hs == pidc_pkg::PIDC_H_BUSREQ)
		|| (st_r.hs == pidc_pkg::PIDC_H_ACK); // R4
	assign o_data = st_r.data;
	assign o_data_oe = (st_r.is == pidc_pkg::PIDC_I_ANSWER); // R15
	assign o_dtack_n = 1'b0;
	assign o_dtack_oe = (st_r.is == pidc_pkg::PIDC_I_ANSWER); // R15
	assign o_intr_taken = st_r.taken;
	assign o_svc_valid = st_r.svc_valid;
	assign o_svc_statid = st_r.svc_statid;
	assign o_svc_level = st_r.hlvl;
endmodule

// ===== verification/pidc_core_sva.sv
// assertions on the ports of pidc_core
// assumes bind from the bench top, one clock domain
`timescale 1ns/1ps
module pidc_core_sva (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_slot1,
	input wire logic i_intr_en,
	input wire logic i_intr_req,
	input wire logic [2:0] i_intr_level,
	input wire logic [2:0] o_svc_level,
	input wire logic [6:0] i_level_mask,
	input wire logic [6:0] i_irq_n,
	input wire logic [6:0] o_irq_n,
	input wire logic [6:0] o_irq_oe,
	input wire logic i_iackin_n,
	input wire logic i_dtb_granted,
	input wire logic i_dtack_n,
	input wire logic o_dtb_want,
	input wire logic o_iack_n,
	input wire logic o_iack_oe,
	input wire logic o_addr_oe,
	input wire logic o_svc_valid,
	input wire logic o_iackout_n,
	input wire logic o_dtack_oe,
	input wire logic o_intr_taken,
	input wire logic [31:0] i_data,
	input wire logic [31:0] o_svc_statid
);
	wire logic [6:0] act = ~i_irq_n & i_level_mask;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	a_irq_one_line: assert property (i_intr_en && i_intr_req && i_intr_level != 3'h0
		|-> (o_irq_oe == (7'h1 << (i_intr_level - 3'h1))) && (o_irq_n == ~o_irq_oe))
		else $error("bad request pins");
	a_best_level: assert property ($rose(o_dtb_want)
		|-> ($past(act) >> (o_svc_level - 3'h1)) == 7'h1) else $error("level not highest");
	a_grant_first: assert property ($rose(o_iack_oe) |-> $past(i_dtb_granted))
		else $error("ack before grant");
	a_ack_drive: assert property (o_iack_oe |-> !o_iack_n && o_addr_oe && o_dtb_want)
		else $error("ack cycle pins");
	a_svc_read: assert property (o_svc_valid
		|-> !$past(i_dtack_n) && o_svc_statid == $past(i_data)) else $error("bad read");
	a_wait_edge: assert property ($rose(o_dtack_oe)
		|-> i_slot1 || $past(i_iackin_n, 2) && !$past(i_iackin_n)) else $error("early answer");
	a_block_chain: assert property (o_dtack_oe |-> o_iackout_n)
		else $error("edge forwarded");
	a_taken_once: assert property (o_intr_taken == $rose(o_dtack_oe))
		else $error("taken pulse wrong");
	a_pass_on: assert property (!i_slot1 && !i_intr_en && $fell(i_iackin_n) |=> !o_iackout_n)
		else $error("edge not passed");
	c_svc: cover property (o_svc_valid);
	c_answer: cover property ($rose(o_dtack_oe));
	c_pass: cover property (!o_iackout_n);
endmodule

// ===== verification/pidc_partner.sv
// far-side boards: data bus requester and the acknowledged interrupter
// assumes it sees the wired bus levels; dtack held until ack released
`timescale 1ns/1ps
module pidc_partner #(parameter int DLY = 2) (
	input wire logic i_clk_sys,
	input wire logic i_want,
	input wire logic i_iack_n,
	input wire logic [2:0] i_lvl,
	output logic o_grant,
	output logic o_dtack_n,
	output logic [31:0] o_data
);
	int cnt = 0;
	// outputs settle during the reset cycles, one driver each
	always @(posedge i_clk_sys) begin
		cnt <= i_iack_n ? 0 : cnt + 1;
		o_grant <= i_want;
		o_dtack_n <= i_iack_n || cnt < DLY;
		// released lines read high through termination
		o_data <= (i_iack_n || cnt < DLY) ? 32'hffffffff : {29'h0a5a5a5a, i_lvl};
	end
endmodule

// ===== verification/tb_priority_interrupt_daisy_chain.sv
// self-checking bench for pidc_core against the far-side model
// assumes 50 ns clock, inputs moved 5 ns after the rising edge
`timescale 1ns/1ps
module tb_priority_interrupt_daisy_chain;
	logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_slot1 = 1'b0, i_handler_en = 1'b1;
	logic i_intr_en = 1'b0, i_intr_req = 1'b0, i_iackin_n = 1'b1, b_iack_n = 1'b1;
	logic [6:0] i_level_mask = 7'h3f, i_irq_n = 7'h7f, o_irq_n, o_irq_oe;
	logic [2:0] i_intr_level = 3'h3, b_addr = 3'h3, o_addr_lvl, o_svc_level;
	logic [1:0] i_intr_size = pidc_pkg::PIDC_W16, i_req_width = pidc_pkg::PIDC_W32, o_req_width;
	logic [31:0] i_intr_statid = 32'h00c0ffee, p_data, o_data, o_svc_statid;
	logic o_intr_taken, o_dtb_want, o_svc_valid, o_iack_n, o_iack_oe, o_iackout_n;
	logic o_addr_oe, o_data_oe, o_dtack_n, o_dtack_oe, p_dtack_n, i_dtb_granted;
	int err_total = 0, checked = 0, cyc = 0;
	wire logic i_iack_n = b_iack_n & ~(o_iack_oe & ~o_iack_n);
	wire logic i_dtack_n = p_dtack_n & ~(o_dtack_oe & ~o_dtack_n);
	wire logic [31:0] i_data = p_data & (o_data_oe ? o_data : 32'hffffffff);
	wire logic [2:0] i_addr_lvl = o_addr_oe ? o_addr_lvl : b_addr;
	pidc_core u_pidc_core (.*);
	pidc_partner u_pidc_partner (.i_clk_sys, .i_want(o_dtb_want), .i_iack_n,
		.i_lvl(i_addr_lvl), .o_grant(i_dtb_granted), .o_dtack_n(p_dtack_n), .o_data(p_data));
	initial forever #25 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			err_total++;
			finish_test;
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#5;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic t_handler(input logic [6:0] req, input logic [2:0] lvl);
		i_irq_n = ~req;
		repeat (20) begin
			step(1);
			if (o_svc_valid === 1'b1) break;
		end
		cmp(o_svc_level, lvl);
		cmp(o_svc_valid, 1'b1);
		cmp(o_svc_statid, {29'h0a5a5a5a, lvl});
		cmp(o_req_width, pidc_pkg::PIDC_W32);
		i_irq_n = 7'h7f;
		step(6);
	endtask
	task automatic t_chain(input logic en, input logic [2:0] a, input logic [1:0] w, input logic ans);
		i_intr_en = en;
		i_intr_req = 1'b1;
		b_addr = a;
		i_req_width = w;
		step(2);
		cmp(o_irq_oe, en ? 7'h04 : 7'h00);
		cmp(o_irq_n, en ? 7'h7b : 7'h7f);
		i_iackin_n = 1'b0;
		step(1);
		cmp(o_intr_taken, ans);
		step(1);
		cmp(o_dtack_oe, ans);
		cmp(o_iackout_n, ans);
		if (ans) cmp(i_data, i_intr_statid);
		i_iackin_n = 1'b1;
		step(3);
		cmp(o_iackout_n, 1'b1);
	endtask
	task automatic t_slot1(input logic en, input logic ans);
		i_intr_en = en;
		i_slot1 = 1'b1;
		b_iack_n = 1'b0;
		step(3);
		cmp(o_dtack_oe, ans);
		cmp(o_iackout_n, ans);
		b_iack_n = 1'b1;
		step(4);
		cmp(o_iackout_n, 1'b1);
		i_slot1 = 1'b0;
	endtask
	initial begin
		step(12);
		i_rst_n = 1'b1;
		step(1);
		t_handler(7'h52, 3'h5);
		i_level_mask = 7'h7f;
		t_handler(7'h52, 3'h7);
		t_chain(1'b1, 3'h3, pidc_pkg::PIDC_W32, 1'b1);
		t_chain(1'b1, 3'h5, pidc_pkg::PIDC_W32, 1'b0);
		t_chain(1'b1, 3'h3, pidc_pkg::PIDC_W8, 1'b0);
		t_chain(1'b0, 3'h3, pidc_pkg::PIDC_W32, 1'b0);
		t_slot1(1'b1, 1'b1);
		t_slot1(1'b0, 1'b0);
		finish_test;
	end
endmodule
bind pidc_core pidc_core_sva u_pidc_core_sva (
	.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n),
	.i_slot1(i_slot1),
	.i_intr_en(i_intr_en),
	.i_intr_req(i_intr_req),
	.i_intr_level(i_intr_level),
	.o_svc_level(o_svc_level),
	.i_level_mask(i_level_mask),
	.i_irq_n(i_irq_n),
	.o_irq_n(o_irq_n),
	.o_irq_oe(o_irq_oe),
	.i_iackin_n(i_iackin_n),
	.i_dtb_granted(i_dtb_granted),
	.i_dtack_n(i_dtack_n),
	.o_dtb_want(o_dtb_want),
	.o_iack_n(o_iack_n),
	.o_iack_oe(o_iack_oe),
	.o_addr_oe(o_addr_oe),
	.o_svc_valid(o_svc_valid),
	.o_iackout_n(o_iackout_n),
	.o_dtack_oe(o_dtack_oe),
	.o_intr_taken(o_intr_taken),
	.i_data(i_data),
	.o_svc_statid(o_svc_statid)
);
